// ==== core/starter_control_source_fsm.sv ====
`timescale 1ns/1ns
`include "starter_defines.svh"
module starter_control_source_fsm
#(
  parameter int RESP_CYCLES = `RESPONSE_CYCLES
)
(
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [1:0]                selector_pins,
  input  wire logic                      run_terminal,
  input  wire logic                      enable_terminal,
  input  wire logic                      overload_pin,
  input  wire logic                      control_source_param,
  input  wire logic [2:0]                frame_size,
  input  wire logic                      profile_load,
  input  wire logic [3:0]                profile_in,
  input  wire starter_pkg::net_cmd_t     net_cmd,
  output logic                           motor_run,
  output logic                           operation_enable,
  output logic                           overload_relay_function,
  output logic [1:0]                     selector_status,
  output logic [3:0]                     profile,
  output starter_pkg::run_state_t        state
);
  import starter_pkg::*;

  // ******************************
  // input synchronisers
  // ******************************
  logic [4:0] pins_s;
  pin_sync #(.WIDTH(5)) u_sync
  (
    .mclk (mclk),
    .rstn (rstn),
    .din  ({selector_pins, run_terminal, enable_terminal, overload_pin}),
    .dout (pins_s)
  );
  selector_t sel;
  logic      run_t;
  logic      en_t;
  logic      ovl;
  always_comb
  begin
    case (pins_s[4:3])
      2'h1:    sel = sel_force_on;
      2'h2:    sel = sel_force_off;
      default: sel = sel_auto;
    endcase
  end
  assign run_t = pins_s[2];
  assign en_t  = pins_s[1];
  assign ovl   = pins_s[0];

  function automatic profile_group_t group_of(input logic [3:0] p);
    case (p)
      4'h1, 4'h2, 4'h3:       group_of = grp_contactor;
      4'h4, 4'h5, 4'h6, 4'hA: group_of = grp_short;
      default:                group_of = grp_long;
    endcase
  endfunction

  // ******************************
  // profile register
  // ******************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      profile <= `PROFILE_RESET;
    else if (profile_load)
      profile <= profile_in;
  end

  // ******************************
  // network sampling, paced by response time
  // ******************************
  // commands are sampled once per response tick, so the delay is bounded
  logic [31:0] tick_cnt;
  logic        tick;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      tick_cnt <= 32'h0;
    else if (tick)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = (tick_cnt >= 32'(RESP_CYCLES - 1));

  net_cmd_t cmd_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cmd_q <= '0;
    else if (tick)
      cmd_q <= net_cmd;
  end

  // ******************************
  // effective command bits
  // ******************************
  logic ovl_active;
  logic want_enable;
  logic want_run;
  logic granted;
  profile_group_t grp;
  assign grp        = group_of(profile);
  assign ovl_active = (sel == sel_auto) && ovl;
  assign granted    = (grp != grp_long) || cmd_q.remote_control_grant_bit;

  always_comb
  begin
    want_enable = 1'b0;
    want_run    = 1'b0;
    if (!control_source_param)
    begin
      want_run    = run_t;
      // small frames lack enable terminal
      want_enable = (frame_size <= `FRAME_SMALL_MAX) ? 1'b1 : en_t;
    end
    else
    begin
      case (grp)
        grp_contactor:
        begin
          want_enable = 1'b1;
          want_run    = cmd_q.start_stop_bit;
        end
        grp_short:
        begin
          want_enable = cmd_q.operation_enable_bit;
          want_run    = cmd_q.run_request_bit;
        end
        default:
        begin
          want_enable = cmd_q.operation_enable_bit;
          want_run    = cmd_q.run_request_bit;
        end
      endcase
    end
  end

  // ******************************
  // run state machine
  // ******************************
  run_state_t next_state;
  logic       net_blocked;
  assign net_blocked = control_source_param && !granted;

  always_comb
  begin
    next_state = state;
    // priority: forced stop, forced run, overload, then commands
    case (sel)
      sel_force_off: next_state = st_ready;
      sel_force_on:  next_state = st_running;
      default:
      begin
        if (ovl_active)
          next_state = st_ready;
        else if (!net_blocked)
        begin
          case (state)
            st_ready:
              if (want_enable)
                next_state = st_operating;
            st_operating:
              if (!want_enable)
                next_state = st_ready;
              else if (want_run)
                next_state = st_running;
            st_running:
              if (!want_enable)
                next_state = st_ready;
              else if (!want_run)
                next_state = st_operating;
            default:
              next_state = st_ready;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state <= st_ready;
    else
      state <= next_state;
  end

  // ******************************
  // outputs
  // ******************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      motor_run               <= 1'b0;
      operation_enable        <= 1'b0;
      overload_relay_function <= 1'b0;
      selector_status         <= `SEL_STAT_UNDEF;
    end
    else
    begin
      motor_run               <= (next_state == st_running);
      operation_enable        <= (next_state != st_ready) && !ovl_active;
      overload_relay_function <= (sel == sel_auto);
      case (sel)
        sel_force_on:  selector_status <= `SEL_STAT_RUN;
        sel_force_off: selector_status <= `SEL_STAT_STOP;
        default:       selector_status <= `SEL_STAT_AUTO;
      endcase
    end
  end

  // ******************************
  // checks
  // ******************************
  chk_forced_off_stop: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_force_off) |=> !motor_run)
    else $error("forced off but motor runs");
  chk_forced_on_run: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_force_on) |=> motor_run)
    else $error("forced on but motor stopped");
  chk_ovl_func_auto: assert property (@(posedge mclk) disable iff (!rstn)
    (sel != sel_auto) |=> !overload_relay_function)
    else $error("overload function on in forced position");
  chk_overload_enable: assert property (@(posedge mclk) disable iff (!rstn)
    ovl_active |=> !operation_enable)
    else $error("enable kept during overload");
  chk_status_code: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_auto) |=> (selector_status == `SEL_STAT_AUTO))
    else $error("wrong selector status");
  chk_grant_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_auto && !ovl_active && net_blocked) |=> $stable(state))
    else $error("transition without grant");
  chk_local_small: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_auto && !ovl_active && !control_source_param
     && frame_size <= `FRAME_SMALL_MAX && state == st_ready)
    |=> (state == st_operating))
    else $error("no automatic entry to operating");
  chk_contactor_auto: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_auto && !ovl_active && control_source_param
     && grp == grp_contactor && state == st_ready) |=> state != st_ready)
    else $error("contactor profile stuck in ready");
  chk_local_run: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == sel_auto && !ovl_active && !control_source_param
     && state == st_operating && want_enable && run_t) |=> motor_run)
    else $error("run terminal ignored");
endmodule

// ==== shared/starter_defines.svh ====
// Function
// - selector forces on, off, or hands to the control source (local or network)
// - overload function active only in automatic position
// - source parameter 0 local, 1 network
// - local run terminal drives run request
// - small frames enter operating state automatically
// - large frames use enable terminal for entry
// - active overload forces operation enable low
// - contactor profiles auto-enter, start/stop bit toggles run
// - short profiles follow run-request bit changes
// - long profiles follow command word bit changes
// - highest priority transition wins
// - network commands answered within about 150 ms
// - selector status 10 auto, 01 stop, 11 run
// - profile 11 selected after reset
`ifndef STARTER_DEFINES_SVH
`define STARTER_DEFINES_SVH
`define SEL_STAT_AUTO      2'h2
`define SEL_STAT_STOP      2'h1
`define SEL_STAT_RUN       2'h3
`define SEL_STAT_UNDEF     2'h0
`define PROFILE_RESET      4'hB
`define RESPONSE_MS        150
`define CLK_HZ             50000000
`define RESPONSE_CYCLES    (`RESPONSE_MS * (`CLK_HZ / 1000))
`define FRAME_SMALL_MAX    3'h2
`endif

// ==== shared/starter_pkg.sv ====
package starter_pkg;
  typedef enum logic [1:0]
  {
    sel_auto     = 2'h0,
    sel_force_on = 2'h1,
    sel_force_off = 2'h2
  } selector_t;
  typedef enum logic [1:0]
  {
    st_ready     = 2'h0,
    st_operating = 2'h1,
    st_running   = 2'h3
  } run_state_t;
  typedef enum logic [1:0]
  {
    grp_contactor = 2'h0,
    grp_short     = 2'h1,
    grp_long      = 2'h2
  } profile_group_t;
  typedef struct packed
  {
    logic start_stop_bit;
    logic run_request_bit;
    logic operation_enable_bit;
    logic remote_control_grant_bit;
  } net_cmd_t;
endpackage

// ==== core/pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ==== bench/plc_model.sv ====
`timescale 1ns/1ns
module plc_model
(
  input  wire logic                  mclk,
  input  wire starter_pkg::net_cmd_t want,
  output starter_pkg::net_cmd_t      net_cmd
);
  import starter_pkg::*;
  // ****************************************
  // gateway frame update
  // ****************************************
  // bench sets want on the falling edge; frame lands one edge later,
  // so there is no race with the bench's own assignment
  always_ff @(posedge mclk)
    net_cmd <= want;
endmodule

// ==== bench/tb_starter_control_source_fsm.sv ====
`timescale 1ns/1ns
`include "starter_defines.svh"
module tb_starter_control_source_fsm;
  import starter_pkg::*;
  localparam int RC = 4;
  logic        mclk, rstn, run_terminal, enable_terminal, overload_pin;
  logic        control_source_param, profile_load, motor_run;
  logic        operation_enable, overload_relay_function;
  logic [1:0]  sel, selector_status;
  logic [2:0]  frame_size;
  logic [3:0]  profile_in, profile, pr;
  logic [10:0] exp_v;
  logic [31:0] seed;
  net_cmd_t    want, net_cmd;
  run_state_t  state;
  logic [10:0] q[$];
  int          errors, checked;
  event        obs;
  int          plist[11] = '{1, 2, 3, 4, 5, 6, 10, 7, 8, 9, 11};

  starter_control_source_fsm #(.RESP_CYCLES(RC)) dut
  (
    .mclk(mclk), .rstn(rstn), .selector_pins(sel),
    .run_terminal(run_terminal), .enable_terminal(enable_terminal),
    .overload_pin(overload_pin), .control_source_param(control_source_param),
    .frame_size(frame_size), .profile_load(profile_load),
    .profile_in(profile_in), .net_cmd(net_cmd), .motor_run(motor_run),
    .operation_enable(operation_enable),
    .overload_relay_function(overload_relay_function),
    .selector_status(selector_status), .profile(profile), .state(state)
  );
  plc_model plc (.mclk(mclk), .want(want), .net_cmd(net_cmd));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // outputs follow from the expected state, selector and loaded profile
  task chk(input run_state_t s, input logic [1:0] st);
    repeat (12) @(negedge mclk);
    q.push_back({pr, s, s == st_running, s != st_ready,
                 st == `SEL_STAT_AUTO, st});
    -> obs;
  endtask

  task cmp_out(input logic [10:0] e);
    checked++;
    if ({profile, state, motor_run, operation_enable,
         overload_relay_function, selector_status} !== e)
    begin
      errors++;
      $display("MISMATCH %0t outputs want %h", $time, e);
    end
  endtask

  always @(obs)
  begin
    exp_v = q.pop_front();
    cmp_out(exp_v);
  end

  task ld(input int p);
    profile_in = 4'(p);
    profile_load = 1'b1;
    @(negedge mclk);
    profile_load = 1'b0;
    pr = 4'(p);
  endtask

  task close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #400000;
    errors++;
    close_out;
  end

  initial
  begin
    seed = 32'h5E57;
    rstn = 1'b0;
    sel = 2'h0;
    {run_terminal, enable_terminal, overload_pin} = 3'h0;
    control_source_param = 1'b0;
    seed = nx(seed);
    frame_size = 3'h1 + {2'h0, seed[0]};
    profile_load = 1'b0;
    profile_in = 4'hB;
    pr = 4'hB;
    want = '0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    chk(st_operating, `SEL_STAT_AUTO);
    run_terminal = 1'b1;
    chk(st_running, `SEL_STAT_AUTO);
    run_terminal = 1'b0;
    chk(st_operating, `SEL_STAT_AUTO);
    $display("local small frame done");
    frame_size = 3'h3;
    overload_pin = 1'b1;
    chk(st_ready, `SEL_STAT_AUTO);
    overload_pin = 1'b0;
    run_terminal = 1'b1;
    chk(st_ready, `SEL_STAT_AUTO);
    enable_terminal = 1'b1;
    chk(st_running, `SEL_STAT_AUTO);
    $display("local large frame done");
    sel = 2'h2;
    chk(st_ready, `SEL_STAT_STOP);
    sel = 2'h1;
    overload_pin = 1'b1;
    chk(st_running, `SEL_STAT_RUN);
    overload_pin = 1'b0;
    control_source_param = 1'b1;
    sel = 2'h2;
    seed = nx(seed);
    want = seed[3:0];
    chk(st_ready, `SEL_STAT_STOP);
    sel = 2'h0;
    $display("selector done");
    foreach (plist[i])
    begin
      ld(plist[i]);
      want = 4'hF;
      chk(st_running, `SEL_STAT_AUTO);
      want = 4'h3;
      chk(st_operating, `SEL_STAT_AUTO);
    end
    $display("profiles done");
    want = 4'hE;
    chk(st_operating, `SEL_STAT_AUTO);
    want = 4'hF;
    chk(st_running, `SEL_STAT_AUTO);
    $display("grant done");
    // let the compare process take the last note before the verdict
    @(negedge mclk);
    close_out;
  end
endmodule
